// ### hdl/shared_pin_function_mux.sv
// Purpose: function select for two shared pins and three pwm/gpio pins
// Assumes: pins are sampled through two flops; registers on a plain port
// Notes: pin outputs are registered except pin two's output enable and the clock-out path
//
// Overview of operation
// - after reset the first pin is interrupt-one input and port B bit 0.
// - interrupt-one sees the pin only when its control enable bit is set.
// - shared pins read as inputs freely; drive only when direction bit or mux bit selects.
// - mux bit 8 set puts timer-2 pwm on the first pin.
// - interrupt-one path depends only on its control, never on mux bit 8.
// - after reset the second pin may serve interrupt, adc, capture or gpio.
// - interrupt-two sees the second pin only when its enable bit is set.
// - adc trigger sees the second pin only when its enable bit is set.
// - capture-one sees the second pin only when configured for it.
// - mux bit 7 set drives the cpu clock onto the second pin.
// - pwm pins four to six each select pwm output or port A gpio.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
module shared_pin_function_mux
  import pin_mux_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic timer2_pwm_out_i,
  input wire logic [2:0] pwm_out_i,
  input wire logic cpu_clock_out_i,
  input wire logic pin_one_i,
  output logic pin_one_o,
  output logic pin_one_oe_o,
  input wire logic pin_two_i,
  output logic pin_two_o,
  output logic pin_two_oe_o,
  input wire logic [2:0] pwm_pin_i,
  output logic [2:0] pwm_pin_o,
  output logic [2:0] pwm_pin_oe_o,
  output logic ext_irq_one_o,
  output logic ext_irq_two_o,
  output logic adc_conv_trigger_in_o,
  output logic capture_in_one_o
);

  logic [DATA_W-1:0] mux_ctrl_a;
  logic [DATA_W-1:0] port_a_data_dir;
  logic [DATA_W-1:0] port_b_data_dir;
  logic [DATA_W-1:0] ext_irq_one_ctrl;
  logic [DATA_W-1:0] ext_irq_two_ctrl;
  logic [DATA_W-1:0] adc_ctrl_second;
  logic [DATA_W-1:0] capture_ctrl;
  logic [NPINS-1:0] lvl_meta;
  logic [NPINS-1:0] lvl_q;
  logic [NPINS-1:0] raw_pins;
  logic pin_two_gpio;
  logic clk_sel;
  logic cap_sel;
  logic [DATA_W-1:0] next_rdata;

  // returns {output enable, output value}; peripheral source wins over gpio
  function automatic logic [1:0] pin_drive(input logic sel, input logic src,
                                           input logic dir, input logic dat);
    pin_drive = sel ? {1'b1, src} : {dir, dat};
  endfunction

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  // register writes; all control resets to zero so pins come up as inputs
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mux_ctrl_a <= REG_RST;
      port_a_data_dir <= REG_RST;
      port_b_data_dir <= REG_RST;
      ext_irq_one_ctrl <= REG_RST;
      ext_irq_two_ctrl <= REG_RST;
      adc_ctrl_second <= REG_RST;
      capture_ctrl <= REG_RST;
    end
    else if (reg_wr_i)
    begin
      case (reg_addr_i)
        OFF_MUX_CTRL_A: mux_ctrl_a <= reg_wdata_i;
        OFF_PORT_A_DATA_DIR: port_a_data_dir <= reg_wdata_i;
        OFF_PORT_B_DATA_DIR: port_b_data_dir <= reg_wdata_i;
        OFF_EXT_IRQ_ONE_CTRL: ext_irq_one_ctrl <= reg_wdata_i;
        OFF_EXT_IRQ_TWO_CTRL: ext_irq_two_ctrl <= reg_wdata_i;
        OFF_ADC_CTRL_SECOND: adc_ctrl_second <= reg_wdata_i;
        OFF_CAPTURE_CTRL: capture_ctrl <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // pin synchroniser; first stage feeds only the second
  assign raw_pins = {pwm_pin_i, pin_two_i, pin_one_i};

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lvl_meta <= '1;
      lvl_q <= '1;
    end
    else
    begin
      lvl_meta <= raw_pins;
      lvl_q <= lvl_meta;
    end
  end

  // register read, data one cycle after the strobe
  always_comb
  begin
    next_rdata = READ_ZERO;
    case (reg_addr_i)
      OFF_MUX_CTRL_A: next_rdata = mux_ctrl_a;
      OFF_PORT_A_DATA_DIR:
      begin
        next_rdata = port_a_data_dir;
        // input bits show the pin level, output bits the latch
        for (int i = 0; i < 3; i++)
          if (!port_a_data_dir[DIR_OFS + A_PWM_FOUR_BIT + i])
            next_rdata[A_PWM_FOUR_BIT + i] = lvl_q[LVL_PWM_LO + i];
        if (!port_a_data_dir[DIR_OFS + A_SHARED_BIT])
          next_rdata[A_SHARED_BIT] = lvl_q[LVL_PIN_TWO];
      end
      OFF_PORT_B_DATA_DIR:
      begin
        next_rdata = port_b_data_dir;
        if (!port_b_data_dir[DIR_OFS + B_SHARED_BIT])
          next_rdata[B_SHARED_BIT] = lvl_q[LVL_PIN_ONE];
      end
      OFF_EXT_IRQ_ONE_CTRL: next_rdata = ext_irq_one_ctrl;
      OFF_EXT_IRQ_TWO_CTRL: next_rdata = ext_irq_two_ctrl;
      OFF_ADC_CTRL_SECOND: next_rdata = adc_ctrl_second;
      OFF_CAPTURE_CTRL: next_rdata = capture_ctrl;
      OFF_PIN_LEVEL_STAT: next_rdata = {{(DATA_W-NPINS){1'b0}}, lvl_q};
      default: next_rdata = READ_ZERO;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= READ_ZERO;
    else if (reg_rd_i)
      reg_rdata_o <= next_rdata;
    else
      reg_rdata_o <= READ_ZERO;
  end

  // pin one: timer-2 pwm or port B bit 0
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      {pin_one_oe_o, pin_one_o} <= 2'b00;
    else
      {pin_one_oe_o, pin_one_o} <= pin_drive(mux_ctrl_a[MUX_TIMER2_PWM_OUT_BIT],
        timer2_pwm_out_i, port_b_data_dir[DIR_OFS + B_SHARED_BIT],
        port_b_data_dir[B_SHARED_BIT]);
  end

  // pwm four to six: compare output or port A bits 4..6
  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_pwm
      always_ff @(posedge mclk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
          {pwm_pin_oe_o[g], pwm_pin_o[g]} <= 2'b00;
        else
          {pwm_pin_oe_o[g], pwm_pin_o[g]} <= pin_drive(
            mux_ctrl_a[MUX_PWM_FOUR_BIT + g], pwm_out_i[g],
            port_a_data_dir[DIR_OFS + A_PWM_FOUR_BIT + g],
            port_a_data_dir[A_PWM_FOUR_BIT + g]);
      end
    end
  endgenerate

  // pin two: the clock cannot pass a flop, so that leg stays combinational
  assign clk_sel = mux_ctrl_a[MUX_CLK_OUT_BIT];

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pin_two_gpio <= 1'b0;
    else
      pin_two_gpio <= port_a_data_dir[A_SHARED_BIT];
  end

  assign pin_two_o = clk_sel ? cpu_clock_out_i : pin_two_gpio;
  assign pin_two_oe_o = clk_sel | port_a_data_dir[DIR_OFS + A_SHARED_BIT];

  // peripheral-facing inputs; a disabled function sees an idle high
  assign cap_sel = capture_ctrl[CAP_EN_BIT] && (capture_ctrl[CAP_EDGE_HI:CAP_EDGE_LO] != 2'b00);

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ext_irq_one_o <= 1'b1;
      ext_irq_two_o <= 1'b1;
      adc_conv_trigger_in_o <= 1'b1;
      capture_in_one_o <= 1'b1;
    end
    else
    begin
      // mux bit 8 deliberately absent: pwm drive is seen back through the pad
      ext_irq_one_o <= ext_irq_one_ctrl[IRQ_EN_BIT] ? lvl_q[LVL_PIN_ONE] : 1'b1;
      ext_irq_two_o <= (!clk_sel && ext_irq_two_ctrl[IRQ_EN_BIT]) ?
        lvl_q[LVL_PIN_TWO] : 1'b1;
      adc_conv_trigger_in_o <= (!clk_sel && adc_ctrl_second[ADC_EXT_SOC_BIT]) ?
        lvl_q[LVL_PIN_TWO] : 1'b1;
      capture_in_one_o <= (!clk_sel && cap_sel) ? lvl_q[LVL_PIN_TWO] : 1'b1;
    end
  end

  pin_one_quiet_a: assert property (
    !mux_ctrl_a[MUX_TIMER2_PWM_OUT_BIT] && !port_b_data_dir[DIR_OFS + B_SHARED_BIT] |=> !pin_one_oe_o)
    else $error("pin one driven without pwm or output select");

  irq_one_gate_a: assert property (
    !ext_irq_one_ctrl[IRQ_EN_BIT] |=> ext_irq_one_o)
    else $error("interrupt one passes pin while disabled");

  irq_one_path_a: assert property (
    ext_irq_one_ctrl[IRQ_EN_BIT] |=> ext_irq_one_o == $past(lvl_q[LVL_PIN_ONE]))
    else $error("interrupt one does not follow pin level");

  gpio_b_drive_a: assert property (
    !mux_ctrl_a[MUX_TIMER2_PWM_OUT_BIT] && port_b_data_dir[DIR_OFS + B_SHARED_BIT]
    |=> pin_one_oe_o && pin_one_o == $past(port_b_data_dir[B_SHARED_BIT]))
    else $error("port B bit 0 output not on pin one");

  timer2_pwm_out_sel_a: assert property (
    mux_ctrl_a[MUX_TIMER2_PWM_OUT_BIT] |=> pin_one_oe_o && pin_one_o == $past(timer2_pwm_out_i))
    else $error("timer-2 pwm not on pin one");

  irq_two_gate_a: assert property (
    !ext_irq_two_ctrl[IRQ_EN_BIT] |=> ext_irq_two_o)
    else $error("interrupt two passes pin while disabled");

  adc_trig_path_a: assert property (
    !clk_sel && adc_ctrl_second[ADC_EXT_SOC_BIT]
    |=> adc_conv_trigger_in_o == $past(lvl_q[LVL_PIN_TWO]))
    else $error("adc trigger does not follow pin two");

  cap_gate_a: assert property (
    !cap_sel |=> capture_in_one_o)
    else $error("capture input passes pin while unconfigured");

  clk_out_a: assert property (
    clk_sel |-> pin_two_oe_o && pin_two_o == cpu_clock_out_i)
    else $error("clock not driven on pin two");

  clk_blind_a: assert property (
    clk_sel |=> ext_irq_two_o && adc_conv_trigger_in_o && capture_in_one_o)
    else $error("peripheral sees pin two during clock out");

  pwm_four_sel_a: assert property (
    mux_ctrl_a[MUX_PWM_FOUR_BIT] |=> pwm_pin_oe_o[0] && pwm_pin_o[0] == $past(pwm_out_i[0]))
    else $error("pwm four not on its pin");

  mux_read_a: assert property (
    reg_rd_i && reg_addr_i == OFF_MUX_CTRL_A |=> reg_rdata_o == $past(mux_ctrl_a))
    else $error("mux control readback wrong");

  irq_with_pwm_c: cover property (mux_ctrl_a[MUX_TIMER2_PWM_OUT_BIT] && ext_irq_one_ctrl[IRQ_EN_BIT]);
  clk_out_c: cover property (clk_sel && ext_irq_two_ctrl[IRQ_EN_BIT]);
  cap_pin_c: cover property (cap_sel && !clk_sel ##1 !capture_in_one_o);

endmodule

// ### hdl/pin_mux_pkg.sv
// Purpose: constants for the shared pin function multiplexer
// Assumes: 16-bit register port with word addresses
// Notes: all register offsets are word indices on the plain register port
package pin_mux_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_MUX_CTRL_A = 3'h0;
  localparam logic [ADDR_W-1:0] OFF_PORT_A_DATA_DIR = 3'h1;
  localparam logic [ADDR_W-1:0] OFF_PORT_B_DATA_DIR = 3'h2;
  localparam logic [ADDR_W-1:0] OFF_EXT_IRQ_ONE_CTRL = 3'h3;
  localparam logic [ADDR_W-1:0] OFF_EXT_IRQ_TWO_CTRL = 3'h4;
  localparam logic [ADDR_W-1:0] OFF_ADC_CTRL_SECOND = 3'h5;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE_CTRL = 3'h6;
  localparam logic [ADDR_W-1:0] OFF_PIN_LEVEL_STAT = 3'h7;

  // mux control fields
  localparam int MUX_PWM_FOUR_BIT = 4;
  localparam int MUX_CLK_OUT_BIT = 7;
  localparam int MUX_TIMER2_PWM_OUT_BIT = 8;

  // port data/direction layout: data in low byte, direction in high byte
  localparam int DIR_OFS = 8;
  localparam int A_PWM_FOUR_BIT = 4;
  localparam int A_SHARED_BIT = 7;
  localparam int B_SHARED_BIT = 0;

  // peripheral enable fields
  localparam int IRQ_EN_BIT = 0;
  localparam int ADC_EXT_SOC_BIT = 0;
  localparam int CAP_EN_BIT = 0;
  localparam int CAP_EDGE_LO = 1;
  localparam int CAP_EDGE_HI = 2;

  // sampled pin indices
  localparam int NPINS = 5;
  localparam int LVL_PIN_ONE = 0;
  localparam int LVL_PIN_TWO = 1;
  localparam int LVL_PWM_LO = 2;

  localparam logic [DATA_W-1:0] REG_RST = 16'h0000;
  localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;
endpackage

// ### verif/board_pins_model.sv
// Purpose: board side of the shared pins, resolving pad levels
// Assumes: every pad has a weak pull-up; board drivers step aside while the device drives
// Notes: a released pad reads high through its pull-up, never the last driven value
`timescale 1ns/1ps
module board_pins_model
(
  input wire logic one_o_i,
  input wire logic one_oe_i,
  input wire logic two_o_i,
  input wire logic two_oe_i,
  input wire logic [2:0] pwm_o_i,
  input wire logic [2:0] pwm_oe_i,
  input wire logic [1:0] drv_en_i,
  input wire logic [1:0] drv_val_i,
  output logic one_lvl_o,
  output logic two_lvl_o,
  output logic [2:0] pwm_lvl_o
);
  assign one_lvl_o = one_oe_i ? one_o_i : (drv_en_i[0] ? drv_val_i[0] : 1'b1);
  assign two_lvl_o = two_oe_i ? two_o_i : (drv_en_i[1] ? drv_val_i[1] : 1'b1);
  // pwm pads have only the pull-up on the board side
  assign pwm_lvl_o = (pwm_oe_i & pwm_o_i) | ~pwm_oe_i;
endmodule

// ### verif/shared_pin_function_mux_tb.sv
// Purpose: self-checking bench for the shared pin function multiplexer
// Assumes: register port read data stands only in the cycle after the read strobe
// Notes: waits of a few cycles cover the two-flop pad synchroniser
`timescale 1ns/1ps
module shared_pin_function_mux_tb
  import pin_mux_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic t2 = 1'b1;
  logic [2:0] pwm_src = 3'h0;
  logic clk_src = 1'b0;
  logic p1_o, p1_oe, p2_o, p2_oe, p1_lvl, p2_lvl;
  logic [2:0] pw_o, pw_oe, pw_lvl;
  logic irq1, irq2, adc, cap;
  logic [1:0] drv_en = 2'h0;
  logic [1:0] drv_val = 2'h3;
  logic [DATA_W-1:0] d;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [ADDR_W-1:0] en_addr [3] = '{OFF_EXT_IRQ_TWO_CTRL, OFF_ADC_CTRL_SECOND, OFF_CAPTURE_CTRL};
  logic [DATA_W-1:0] en_val [3] = '{16'h0001, 16'h0001, 16'h0003};

  shared_pin_function_mux u_shared_pin_function_mux (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .timer2_pwm_out_i(t2), .pwm_out_i(pwm_src), .cpu_clock_out_i(clk_src),
    .pin_one_i(p1_lvl), .pin_one_o(p1_o), .pin_one_oe_o(p1_oe),
    .pin_two_i(p2_lvl), .pin_two_o(p2_o), .pin_two_oe_o(p2_oe),
    .pwm_pin_i(pw_lvl), .pwm_pin_o(pw_o), .pwm_pin_oe_o(pw_oe),
    .ext_irq_one_o(irq1), .ext_irq_two_o(irq2), .adc_conv_trigger_in_o(adc),
    .capture_in_one_o(cap));

  board_pins_model u_board_pins_model (.one_o_i(p1_o), .one_oe_i(p1_oe), .two_o_i(p2_o),
    .two_oe_i(p2_oe), .pwm_o_i(pw_o), .pwm_oe_i(pw_oe), .drv_en_i(drv_en),
    .drv_val_i(drv_val), .one_lvl_o(p1_lvl), .two_lvl_o(p2_lvl), .pwm_lvl_o(pw_lvl));

  always #25 mclk_i = ~mclk_i;

  always @(posedge mclk_i)
  begin
    clk_src <= ~clk_src;
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      num_errors = num_errors + 1;
      wrap_up();
    end
  end

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge mclk_i);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    step(1);
    chk(p1_oe, 1'b0);
    chk(irq1, 1'b1);
    chk(p2_oe, 1'b0);
    rd_reg(OFF_MUX_CTRL_A);
    chk(d, REG_RST);
    // board pulls pin one low while its interrupt is still off
    @(posedge mclk_i);
    drv_en <= 2'h3;
    drv_val <= 2'h0;
    step(4);
    chk(irq1, 1'b1);
    // input bits read the pads: pwm pads pulled high, pin two held low
    rd_reg(OFF_PORT_A_DATA_DIR);
    chk(d, 16'h0070);
    wr_reg(OFF_EXT_IRQ_ONE_CTRL, 16'h0001);
    step(4);
    chk(irq1, 1'b0);
    rd_reg(OFF_PIN_LEVEL_STAT);
    chk({11'h0, d[4:0]}, 16'h001C);
    @(posedge mclk_i);
    drv_en <= 2'h2;
    wr_reg(OFF_PORT_B_DATA_DIR, 16'h0101);
    step(3);
    chk({p1_oe, p1_o}, 2'h3);
    // pwm low must win over a gpio driving high
    @(posedge mclk_i);
    t2 <= 1'b0;
    wr_reg(OFF_MUX_CTRL_A, 16'h0100);
    step(3);
    chk({p1_oe, p1_o}, 2'h2);
    step(3);
    chk(irq1, 1'b0);
    wr_reg(OFF_EXT_IRQ_ONE_CTRL, 16'h0000);
    @(posedge mclk_i);
    t2 <= 1'b1;
    step(4);
    chk(irq1, 1'b1);
    chk(p1_o, 1'b1);
    // second pin held low: each peripheral sees it only when enabled
    chk({irq2, adc, cap}, 3'h7);
    wr_reg(OFF_CAPTURE_CTRL, 16'h0001);
    step(4);
    chk(cap, 1'b1);
    for (int k = 0; k < 3; k++)
    begin
      wr_reg(en_addr[k], en_val[k]);
      step(4);
      chk({irq2, adc, cap}, 3'h7 & ~(3'h4 >> k));
      wr_reg(en_addr[k], 16'h0000);
    end
    for (int k = 0; k < 3; k++)
      wr_reg(en_addr[k], en_val[k]);
    step(4);
    chk({irq2, adc, cap}, 3'h0);
    @(posedge mclk_i);
    drv_en <= 2'h0;
    wr_reg(OFF_MUX_CTRL_A, 16'h0080);
    step(4);
    chk({irq2, adc, cap}, 3'h7);
    chk({p2_oe, p2_o}, {1'b1, clk_src});
    step(1);
    chk(p2_o, clk_src);
    chk({irq2, adc, cap}, 3'h7);
    wr_reg(OFF_MUX_CTRL_A, 16'h0000);
    wr_reg(OFF_PORT_A_DATA_DIR, 16'h8000);
    step(3);
    chk({p2_oe, p2_o}, 2'h2);
    @(posedge mclk_i);
    pwm_src <= 3'h5;
    wr_reg(OFF_MUX_CTRL_A, 16'h0070);
    step(3);
    chk({pw_oe, pw_o}, 6'h3D);
    wr_reg(OFF_PORT_A_DATA_DIR, 16'h7020);
    step(3);
    chk({pw_oe, pw_o}, 6'h3D);
    wr_reg(OFF_MUX_CTRL_A, 16'h0000);
    step(3);
    chk({pw_oe, pw_o}, 6'h3A);
    wrap_up();
  end
endmodule
